// ===== logic/fpc_top.sv
// protect and function configuration logic with apb register access
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module fpc_top #(
	parameter logic RESET_OFF_DEFAULT = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_protect_n_pin,
	output logic write_protect_active,
	output logic quad_lines_enable,
	output logic hold_reset_is_reset,
	output logic dedicated_reset_enable,
	output logic op_allowed,
	output logic op_blocked
);
	// ****************
	// pin synchroniser
	// ****************
	logic wp_meta, wp_sync;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
		end else begin
			wp_meta <= write_protect_n_pin;
			wp_sync <= wp_meta;
		end
	end

	// ****************
	// state
	// ****************
	logic [7:0] status, next_status;
	logic [7:0] func, next_func;
	logic [2:0] cmd_op, next_cmd_op;
	logic [24:0] cmd_addr, next_cmd_addr;
	logic [1:0] cmd_row, next_cmd_row;
	logic prog_busy, next_prog_busy;
	logic erase_busy, next_erase_busy;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_allowed, next_blocked;
	logic next_wp_active, next_quad_lines;
	logic next_hold_reset, next_dedicated_reset;
	logic strap_done, next_strap_done;
	logic [3:0] protect_level;
	logic [8:0] block_index;
	logic range_hit;
	logic status_locked;
	logic wr_access, rd_access;
	logic wr_status, wr_func, wr_cmd;
	logic cmd_eval;

	// ****************
	// elaboration checks
	// ****************
	// the range decoder takes a nine-bit block index
	if (fpc_pkg::FPC_ADDR_BLK_HI - fpc_pkg::FPC_ADDR_BLK_LO != 8) begin : g_block_width
		$error("block index must be nine bits wide");
	end
	// the block count must match the nine-bit index
	if (fpc_pkg::FPC_BLOCKS != 512) begin : g_block_count
		$error("range decoder serves exactly 512 blocks");
	end

	// ****************
	// protected range
	// ****************
	// R19 block index is the 64 KB unit of the target address
	assign block_index = cmd_addr[fpc_pkg::FPC_ADDR_BLK_HI:fpc_pkg::FPC_ADDR_BLK_LO];
	assign protect_level = status[fpc_pkg::FPC_SR_BP_LO + 3:fpc_pkg::FPC_SR_BP_LO];

	fpc_range u_range (
		.level(protect_level),
		.bottom(func[fpc_pkg::FPC_FR_TBS]),
		.block(block_index),
		.hit(range_hit)
	);

	// ****************
	// access decode
	// ****************
	assign wr_access = psel && penable && pwrite && !pready;
	assign rd_access = psel && penable && !pwrite && !pready;
	assign wr_status = wr_access && paddr == fpc_pkg::FPC_ADDR_STATUS;
	assign wr_func = wr_access && paddr == fpc_pkg::FPC_ADDR_FUNC;
	assign wr_cmd = wr_access && paddr == fpc_pkg::FPC_ADDR_CMD;
	// stored command is judged once the bus write has gone by
	assign cmd_eval = !wr_access && cmd_op != 3'h0;
	// R6 R7 hardware status protection
	assign status_locked = status[fpc_pkg::FPC_SR_SWD] && !wp_sync;

	// ****************
	// bus response
	// ****************
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (wr_access && !(wr_status || wr_func || wr_cmd))
			next_pslverr = 1'b1;
		if (rd_access) begin
			unique case (paddr)
				fpc_pkg::FPC_ADDR_STATUS: next_prdata = {24'h000000, status};
				fpc_pkg::FPC_ADDR_FUNC: next_prdata = {24'h000000, func};
				fpc_pkg::FPC_ADDR_CMD:
					next_prdata = {cmd_addr, 2'h0, cmd_row, cmd_op};
				fpc_pkg::FPC_ADDR_RESULT:
					next_prdata = {30'h0, op_blocked, op_allowed};
				fpc_pkg::FPC_ADDR_PINS:
					next_prdata = {30'h0, status_locked, wp_sync};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************
	// status register
	// ****************
	always_comb begin
		next_status = status;
		// R18 only a status write changes the non-volatile bits
		// R6 R7 the write is dropped while the lock holds
		if (wr_status && !status_locked)
			next_status = (pwdata[7:0] & fpc_pkg::FPC_STATUS_WMASK)
				| (status & ~fpc_pkg::FPC_STATUS_WMASK);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// R17 status resets to zero
			status <= fpc_pkg::FPC_STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// ****************
	// function register
	// ****************
	always_comb begin
		next_func = func;
		next_strap_done = 1'b1;
		// R10 part-dependent reset-off bit loaded after release
		if (!strap_done)
			next_func[fpc_pkg::FPC_FR_RST_OFF] = RESET_OFF_DEFAULT;
		// R11 R12 R13 R16 one-time bits can only be set
		if (wr_func)
			next_func = next_func | (pwdata[7:0] & fpc_pkg::FPC_FUNC_OTP_MASK);
		if (cmd_eval) begin
			unique case (cmd_op)
				fpc_pkg::FPC_OP_SUSPEND: begin
					// R14 R15 flag the work that was running
					if (prog_busy)
						next_func[fpc_pkg::FPC_FR_PROGRAM_SUSPENDED_FLAG] = 1'b1;
					if (erase_busy)
						next_func[fpc_pkg::FPC_FR_ERASE_SUSPENDED_FLAG] = 1'b1;
				end
				fpc_pkg::FPC_OP_RESUME, fpc_pkg::FPC_OP_START: begin
					// R14 R15 flags drop on resume or completion
					next_func[fpc_pkg::FPC_FR_PROGRAM_SUSPENDED_FLAG] = 1'b0;
					next_func[fpc_pkg::FPC_FR_ERASE_SUSPENDED_FLAG] = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// R10 function bits reset to zero
			func <= 8'h00;
			strap_done <= 1'b0;
		end else begin
			func <= next_func;
			strap_done <= next_strap_done;
		end
	end

	// ****************
	// command judgement
	// ****************
	always_comb begin
		next_cmd_op = cmd_op;
		next_cmd_addr = cmd_addr;
		next_cmd_row = cmd_row;
		next_prog_busy = prog_busy;
		next_erase_busy = erase_busy;
		next_allowed = 1'b0;
		next_blocked = 1'b0;
		if (wr_cmd) begin
			next_cmd_op = pwdata[2:0];
			next_cmd_addr = pwdata[31:7];
			next_cmd_row = pwdata[4:3];
		end
		if (cmd_eval) begin
			next_cmd_op = 3'h0;
			unique case (cmd_op)
				fpc_pkg::FPC_OP_PROG: begin
					// R1 R19 inhibit a program inside the protected range
					next_allowed = !range_hit;
					next_prog_busy = !range_hit || prog_busy;
				end
				fpc_pkg::FPC_OP_ERASE: begin
					// R1 R19 inhibit an erase inside the protected range
					next_allowed = !range_hit;
					next_erase_busy = !range_hit || erase_busy;
				end
				fpc_pkg::FPC_OP_CHIP: begin
					// R5 full-array erase needs protect level zero
					next_allowed = (protect_level == 4'h0);
					next_erase_busy = (protect_level == 4'h0) || erase_busy;
				end
				fpc_pkg::FPC_OP_ROWPROG: begin
					// R16 a locked row refuses programming
					next_allowed = !func[fpc_pkg::FPC_FR_IRL_LO + 32'(cmd_row)];
				end
				fpc_pkg::FPC_OP_SUSPEND: begin
					// R14 R15 suspend needs running work
					next_allowed = prog_busy || erase_busy;
				end
				fpc_pkg::FPC_OP_RESUME: begin
					next_allowed = 1'b1;
				end
				fpc_pkg::FPC_OP_START: begin
					// running work completes
					next_allowed = 1'b1;
					next_prog_busy = 1'b0;
					next_erase_busy = 1'b0;
				end
				default: next_allowed = 1'b0;
			endcase
			next_blocked = !next_allowed;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_op <= 3'h0;
			cmd_addr <= 25'h0;
			cmd_row <= 2'h0;
			prog_busy <= 1'b0;
			erase_busy <= 1'b0;
			op_allowed <= 1'b0;
			op_blocked <= 1'b0;
		end else begin
			cmd_op <= next_cmd_op;
			cmd_addr <= next_cmd_addr;
			cmd_row <= next_cmd_row;
			prog_busy <= next_prog_busy;
			erase_busy <= next_erase_busy;
			op_allowed <= next_allowed;
			op_blocked <= next_blocked;
		end
	end

	// ****************
	// pin function
	// ****************
	always_comb begin
		// R6 R7 lock shown toward the pins
		next_wp_active = status_locked;
		// R8 extra pins become quad data lines
		next_quad_lines = next_status[fpc_pkg::FPC_SR_QE];
		// R12 reset moves to the shared pin while it is not a data line
		next_hold_reset = next_func[fpc_pkg::FPC_FR_RST_OFF]
			&& !next_status[fpc_pkg::FPC_SR_QE];
		next_dedicated_reset = !next_func[fpc_pkg::FPC_FR_RST_OFF];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			write_protect_active <= 1'b0;
			quad_lines_enable <= 1'b0;
			hold_reset_is_reset <= 1'b0;
			dedicated_reset_enable <= 1'b1;
		end else begin
			write_protect_active <= next_wp_active;
			quad_lines_enable <= next_quad_lines;
			hold_reset_is_reset <= next_hold_reset;
			dedicated_reset_enable <= next_dedicated_reset;
		end
	end
endmodule // fpc_top

// ===== common/fpc_pkg.sv
// constants for the flash protect and function configuration block
// How it works
// R1: program or erase inside the protected area is inhibited
// R2: top select: level 0 none, 1-9 highest 2^(n-1) blocks, 10-15 all
// R3: bottom select: level 1-9 lowest 2^(n-1) blocks from zero, 10-15 all
// R4: unit is 64 KB block; upper levels ignore lower bits
// R5: full-array erase ignored unless all protect bits are zero
// R6: disable bit set and write-protect pin low makes status read-only
// R7: disable bit clear or pin high lets status write update status
// R8: quad enable zero: pins are protect/hold; one: quad data lines
// R9: host keeps quad enable zero when those pins tie to supply
// R10: function register bit layout; all zero except part-dependent bit 0
// R11: one-time bits once one never return to zero
// R12: reset-off bit moves reset function onto hold-or-reset pin
// R13: selector defaults to top; bottom is permanent
// R14: program-suspended flag sets on suspend, clears on resume
// R15: erase-suspended flag sets on suspend, clears on resume
// R16: row lock bits default zero; once set refuse row programming
// R17: status bit 7 disable, 6 quad enable, 5..2 protect level
// R18: non-volatile status bits change only via status write command
// R19: block index is address bits 24 down to 16
package fpc_pkg;
	localparam logic [7:0] FPC_ADDR_STATUS = 8'h00;
	localparam logic [7:0] FPC_ADDR_FUNC = 8'h04;
	localparam logic [7:0] FPC_ADDR_CMD = 8'h08;
	localparam logic [7:0] FPC_ADDR_RESULT = 8'h0C;
	localparam logic [7:0] FPC_ADDR_PINS = 8'h10;
	localparam int FPC_SR_SWD = 7;
	localparam int FPC_SR_QE = 6;
	localparam int FPC_SR_BP_LO = 2;
	localparam int FPC_FR_RST_OFF = 0;
	localparam int FPC_FR_TBS = 1;
	localparam int FPC_FR_PROGRAM_SUSPENDED_FLAG = 2;
	localparam int FPC_FR_ERASE_SUSPENDED_FLAG = 3;
	localparam int FPC_FR_IRL_LO = 4;
	localparam logic [7:0] FPC_STATUS_RESET = 8'h00;
	localparam logic [7:0] FPC_STATUS_WMASK = 8'hFC;
	localparam logic [7:0] FPC_FUNC_OTP_MASK = 8'hF3;
	localparam int FPC_ADDR_BLK_HI = 24;
	localparam int FPC_ADDR_BLK_LO = 16;
	localparam int FPC_BLOCKS = 512;
	// operation codes in the command register
	localparam logic [2:0] FPC_OP_PROG = 3'h1;
	localparam logic [2:0] FPC_OP_ERASE = 3'h2;
	localparam logic [2:0] FPC_OP_CHIP = 3'h3;
	localparam logic [2:0] FPC_OP_ROWPROG = 3'h4;
	localparam logic [2:0] FPC_OP_SUSPEND = 3'h5;
	localparam logic [2:0] FPC_OP_RESUME = 3'h6;
	localparam logic [2:0] FPC_OP_START = 3'h7;
	localparam logic [7:0] FPC_STATUS_WRITE_CODE = 8'h01;
endpackage

// ===== logic/fpc_range.sv
// protected block range decoder and compare
`timescale 1ns/10ps
module fpc_range (
	input wire logic [3:0] level,
	input wire logic bottom,
	input wire logic [8:0] block,
	output logic hit
);
	logic [9:0] count;
	// R4 level decode with don't-care
	always_comb begin
		if (level == 4'h0)
			count = 10'h000;
		else if (level >= 4'hA)
			count = 10'h200;
		else
			count = 10'(10'h001 << (level - 4'h1));
	end
	// R2 R3 top or bottom compare
	always_comb begin
		if (bottom)
			hit = {1'b0, block} < count;
		else
			hit = (10'h200 - {1'b0, block}) <= count;
	end
endmodule // fpc_range

// ===== testbench/fpc_pin_model.sv
// board wiring of the write-protect pin
`timescale 1ns/10ps
module fpc_pin_model (
	input wire logic level,
	output logic write_protect_n_pin
);
	assign write_protect_n_pin = level;
endmodule // fpc_pin_model

// ===== testbench/fpc_top_properties.sv
// port assertions of the protect block
`timescale 1ns/10ps
module fpc_top_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic write_protect_n_pin,
	input wire logic write_protect_active,
	input wire logic quad_lines_enable,
	input wire logic dedicated_reset_enable,
	input wire logic op_allowed,
	input wire logic op_blocked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic st_wr;
	assign st_wr = psel && penable && pwrite && paddr == fpc_pkg::FPC_ADDR_STATUS;
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("lone error");
	property p_excl; !(op_allowed && op_blocked); endproperty
	a_excl: assert property (p_excl) else $error("two results");
	property p_pulse; op_allowed || op_blocked |=> !(op_allowed || op_blocked); endproperty
	a_pulse: assert property (p_pulse) else $error("result held");
	property p_otp; !$rose(dedicated_reset_enable); endproperty
	a_otp: assert property (p_otp) else $error("bit 0 cleared");
	property p_wp; write_protect_n_pin [*4] |-> !write_protect_active; endproperty
	a_wp: assert property (p_wp) else $error("locked, pin high");
	property p_qe; $changed(quad_lines_enable) |-> $past(st_wr) || $past(st_wr, 2); endproperty
	a_qe: assert property (p_qe) else $error("quad moved alone");
	c_ok: cover property (op_allowed);
	c_no: cover property (op_blocked);
	c_wp: cover property (write_protect_active);
endmodule // fpc_top_properties
bind fpc_top fpc_top_properties fpc_top_properties_i (
	.clk(clk),
	.reset(reset),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.write_protect_n_pin(write_protect_n_pin),
	.write_protect_active(write_protect_active),
	.quad_lines_enable(quad_lines_enable),
	.dedicated_reset_enable(dedicated_reset_enable),
	.op_allowed(op_allowed),
	.op_blocked(op_blocked)
);

// ===== testbench/fpc_top_tb_top.sv
// self-checking bench of the protect block
`timescale 1ns/10ps
module fpc_top_tb_top;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, level = 1, err, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, write_protect_n_pin, write_protect_active, quad_lines_enable;
	logic hold_reset_is_reset, dedicated_reset_enable, op_allowed, op_blocked, sok, sno;
	int bad_count = 0, checks_done = 0, cyc = 0, b;
	always #4 clk = ~clk;
	fpc_pin_model fpc_pin_model_i (.level(level), .write_protect_n_pin(write_protect_n_pin));
	fpc_top fpc_top_i (
		.clk(clk),
		.reset(reset),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.write_protect_n_pin(write_protect_n_pin),
		.write_protect_active(write_protect_active),
		.quad_lines_enable(quad_lines_enable),
		.hold_reset_is_reset(hold_reset_is_reset),
		.dedicated_reset_enable(dedicated_reset_enable),
		.op_allowed(op_allowed),
		.op_blocked(op_blocked)
	);
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 9000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// ready seen settled before the edge that samples it
		do @(negedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic f, input logic [31:0] d);
		apb(1'b1, f ? fpc_pkg::FPC_ADDR_FUNC : fpc_pkg::FPC_ADDR_STATUS, d);
	endtask
	task automatic rchk(input logic f, input logic [31:0] exp);
		apb(1'b0, f ? fpc_pkg::FPC_ADDR_FUNC : fpc_pkg::FPC_ADDR_STATUS, 32'h0);
		chk(rd, exp);
	endtask
	task automatic op(input logic [2:0] c, input int bk, input int row);
		apb(1'b1, fpc_pkg::FPC_ADDR_CMD, (32'(bk) << 23) | (32'(row) << 3) | 32'(c));
		sok = 1'b0;
		sno = 1'b0;
		repeat (4) begin
			@(negedge clk);
			if (op_allowed === 1'b1)
				sok = 1'b1;
			if (op_blocked === 1'b1)
				sno = 1'b1;
		end
	endtask
	function automatic int cnt(int lv);
		return (lv == 0) ? 0 : (lv >= 10) ? 512 : (1 << (lv - 1));
	endfunction
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rchk(1'b0, 32'h0);
		rchk(1'b1, 32'h0);
		chk(dedicated_reset_enable, 1'b1);
		apb(1'b0, 8'h14, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		for (int t = 0; t < 2; t++) begin
			for (int lv = 0; lv < 16; lv++) begin
				wr(1'b0, 32'(lv) << 2);
				for (int k = 0; k < 2; k++) begin
					b = ((t == 1 ? cnt(lv) : 512 - cnt(lv)) - k) & 511;
					op(k == 1 ? fpc_pkg::FPC_OP_ERASE : fpc_pkg::FPC_OP_PROG, b, 0);
					e = (t == 1) ? (b < cnt(lv)) : (b >= 512 - cnt(lv));
					chk({sno, sok}, {e, !e});
				end
				op(fpc_pkg::FPC_OP_CHIP, 0, 0);
				chk({sno, sok}, {lv != 0, lv == 0});
			end
			wr(1'b1, 32'h02);
			wr(1'b1, 32'h00);
			rchk(1'b1, 32'h02);
		end
		$display("test ranges done");
		wr(1'b0, 32'h0);
		for (int k = 0; k < 2; k++) begin
			op(fpc_pkg::FPC_OP_START, 0, 0);
			chk({sno, sok}, 2'b01);
			op(k == 1 ? fpc_pkg::FPC_OP_ERASE : fpc_pkg::FPC_OP_PROG, 3, 0);
			op(fpc_pkg::FPC_OP_SUSPEND, 0, 0);
			rchk(1'b1, k == 1 ? 32'h0A : 32'h06);
			op(fpc_pkg::FPC_OP_RESUME, 0, 0);
			rchk(1'b1, 32'h02);
		end
		wr(1'b1, 32'h11);
		op(fpc_pkg::FPC_OP_ROWPROG, 0, 0);
		chk({sno, sok}, 2'b10);
		op(fpc_pkg::FPC_OP_ROWPROG, 0, 1);
		chk({sno, sok}, 2'b01);
		wr(1'b1, 32'h00);
		rchk(1'b1, 32'h13);
		chk({dedicated_reset_enable, hold_reset_is_reset}, 2'b01);
		$display("test function done");
		wr(1'b0, 32'h84);
		level <= 1'b0;
		repeat (5) @(posedge clk);
		chk(write_protect_active, 1'b1);
		apb(1'b0, fpc_pkg::FPC_ADDR_PINS, 32'h0);
		chk(rd, 32'h2);
		wr(1'b0, 32'h40);
		rchk(1'b0, 32'h84);
		level <= 1'b1;
		repeat (5) @(posedge clk);
		wr(1'b0, 32'h40);
		rchk(1'b0, 32'h40);
		chk({write_protect_active, quad_lines_enable, hold_reset_is_reset}, 3'b010);
		$display("test status done");
		wrap_up();
	end
endmodule // fpc_top_tb_top
